//--- frpd_defs.svh
// Constants for the flash read-parameter and power-down block.
`ifndef FRPD_DEFS_SVH
`define FRPD_DEFS_SVH
`define FRPD_CMD_SET_PARAM 8'hC0
`define FRPD_CMD_WRAP 8'h77
`define FRPD_CMD_PDOWN 8'hB9
`define FRPD_CMD_RELEASE 8'hAB
`define FRPD_CMD_RST_EN 8'h66
`define FRPD_CMD_RST 8'h99
`define FRPD_CMD_QPI_ON 8'h38
`define FRPD_CMD_QPI_OFF 8'hFF
`define FRPD_CMD_WREN 8'h06
`define FRPD_CMD_PP 8'h02
`define FRPD_CMD_SE 8'h20
`define FRPD_DUMMY_RST 2'h3
`define FRPD_WRAPDIS_RST 1'h1
`define FRPD_WRAPLEN_RST 2'h0
`define FRPD_DUMMY_BIT 4
`define FRPD_WRAPDIS_BIT 2
`define FRPD_WRAPLEN_BIT 0
`define FRPD_WRAP_WDIS_BIT 4
`define FRPD_WRAP_WLEN_BIT 5
`define FRPD_CLK_NS 4
`define FRPD_TDP_NS 3000
`define FRPD_WAKE_RECOVERY_TIME_NS 8000
`define FRPD_WAKE_WITH_ID_RECOVERY_TIME_NS 8000
`define FRPD_TDP_CYC ((`FRPD_TDP_NS + `FRPD_CLK_NS - 1) / `FRPD_CLK_NS)
`define FRPD_WAKE_RECOVERY_TIME_CYC ((`FRPD_WAKE_RECOVERY_TIME_NS + `FRPD_CLK_NS - 1) / `FRPD_CLK_NS)
`define FRPD_WAKE_WITH_ID_RECOVERY_TIME_CYC ((`FRPD_WAKE_WITH_ID_RECOVERY_TIME_NS + `FRPD_CLK_NS - 1) / `FRPD_CLK_NS)
`define FRPD_HOST_DIV 4
`define FRPD_WIP_CYC 64
`endif

//--- frpd_pkg.sv
// Types for the two ends of the flash command link, one enum per end.
package frpd_pkg;
	typedef enum {FRPD_DEV_STANDBY, FRPD_DEV_ENTERING, FRPD_DEV_PDOWN,
		FRPD_DEV_WAKING} frpd_pwr_t;
	typedef enum {FRPD_H_IDLE, FRPD_H_SHIFT, FRPD_H_GAP} frpd_hstate_t;
endpackage

//--- frpd_link_if.sv
// Link between host controller and flash device: select, clock, data lines.
`timescale 1ns/1ps
interface frpd_link_if;
	logic cs_n;
	logic sck;
	logic [3:0] io_host;
	logic [3:0] io_host_oe;
	logic [3:0] io_dev;
	logic [3:0] io_dev_oe;
	modport dev (input cs_n, input sck, input io_host, input io_host_oe,
		output io_dev, output io_dev_oe);
	modport host (output cs_n, output sck, output io_host,
		output io_host_oe, input io_dev, input io_dev_oe);
endinterface

//--- frpd_device.sv
// Flash device end: read parameters, wrap control and deep power-down.
// Functional notes
// - Quad-mode read-parameter command sets dummy count.
// - Serial mode rejects the read-parameter command.
// - Host reprograms dummy count after entering quad.
// - Leaving quad mode restores default dummy count.
// - Reset gives 8-byte wrap, 8 dummy clocks.
// - One wrap length shared by both modes.
// - Wrap disable bit, default one, gates wrap.
// - Wrapping address returns to aligned section start.
// - Dedicated wrap reads always wrap in quad.
// - Dummy select 00/01=4, 10=6, 11=8.
// - Wrap select 00=8,01=16,10=32,11=64 bytes.
// - Only power-down command enters lowest power.
// - Power-down ignores all but release and reset.
// - Power-down needs select rise at bit eight.
// - Power-down entry completes after entry time.
// - Power-down rejected while write cycle runs.
// - Power-up always lands in standby.
// - Bare release blocks commands for recovery time.
// - Release with three dummies shifts identification byte.
// - Identification wake blocks commands for its own recovery time, same by default.
// - Release ignored while write in progress.
// - Select high without cycle means standby.
`timescale 1ns/1ps
`include "frpd_defs.svh"
module frpd_device #(
	parameter logic [7:0] ID_BYTE = 8'h5A, // Arbitrary value.
	parameter int TDP_CYC = `FRPD_TDP_CYC,
	parameter int WAKE_RECOVERY_TIME_CYC = `FRPD_WAKE_RECOVERY_TIME_CYC,
	parameter int WAKE_WITH_ID_RECOVERY_TIME_CYC = `FRPD_WAKE_WITH_ID_RECOVERY_TIME_CYC,
	parameter int WIP_CYC = `FRPD_WIP_CYC
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Link
	frpd_link_if.dev LINK,
	// Status
	output logic QUAD_MODE,
	output logic DEEP_POWER_DOWN,
	output logic STANDBY,
	output logic BUSY_RECOVERING,
	output logic WRITE_IN_PROGRESS_FLAG,
	output logic [3:0] DUMMY_CLOCKS,
	output logic WRAP_DISABLE_BIT,
	output logic [6:0] WRAP_BYTES,
	// Wrapping address walk
	input wire logic [23:0] READ_ADDR,
	input wire logic DEDICATED_WRAP_READ,
	output logic [23:0] NEXT_ADDR
);
	import frpd_pkg::*;

	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] sck_s;
		logic [3:0] io_s1;
		logic [3:0] io_s2;
		logic [5:0] bitcnt;
		logic [7:0] cmd;
		logic [31:0] sh;
		logic quad;
		logic rst_en;
		logic [1:0] dummy_count_select;
		logic wrap_disable_bit;
		logic [1:0] wrap_length_select;
		frpd_pwr_t pwr;
		logic [15:0] timer;
		logic [15:0] wip_cnt;
		logic wel;
		logic [2:0] idx;
		logic so;
	} frpd_dev_state_t;

	frpd_dev_state_t st_ff;
	frpd_dev_state_t nxt_st;

	function automatic logic [3:0] dummy_of(input logic [1:0] sel);
		unique case (sel)
			2'h0, 2'h1: dummy_of = 4'h4;
			2'h2: dummy_of = 4'h6;
			2'h3: dummy_of = 4'h8;
		endcase
	endfunction

	function automatic logic [6:0] wrap_of(input logic [1:0] sel);
		wrap_of = 7'h08 << sel;
	endfunction

	logic cs_n_s;
	logic cs_rise;
	logic cs_fall;
	logic sck_rise;
	logic sck_fall;
	logic cmd_ok;
	logic [5:0] width;
	logic [5:0] mask;

	assign cs_n_s = st_ff.cs_s[1];
	assign cs_rise = st_ff.cs_s[1] & ~st_ff.cs_s[2];
	assign cs_fall = ~st_ff.cs_s[1] & st_ff.cs_s[2];
	assign sck_rise = st_ff.sck_s[1] & ~st_ff.sck_s[2];
	assign sck_fall = ~st_ff.sck_s[1] & st_ff.sck_s[2];
	assign width = st_ff.quad ? 6'h04 : 6'h01;
	assign cmd_ok = (st_ff.bitcnt == 6'h08);
	assign mask = 6'(wrap_of(st_ff.wrap_length_select) - 7'h01);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.cs_s = {st_ff.cs_s[1:0], LINK.cs_n};
		nxt_st.sck_s = {st_ff.sck_s[1:0], LINK.sck};
		nxt_st.io_s1 = LINK.io_host;
		nxt_st.io_s2 = st_ff.io_s1;
		if (st_ff.wip_cnt != 16'h0000) begin
			nxt_st.wip_cnt = st_ff.wip_cnt - 16'h0001;
		end
		if (st_ff.timer != 16'h0000) begin
			nxt_st.timer = st_ff.timer - 16'h0001;
		end
		unique case (st_ff.pwr)
			FRPD_DEV_ENTERING: if (st_ff.timer == 16'h0000) begin
				nxt_st.pwr = FRPD_DEV_PDOWN;
			end
			FRPD_DEV_WAKING: if (st_ff.timer == 16'h0000) begin
				nxt_st.pwr = FRPD_DEV_STANDBY;
			end
			default: ;
		endcase
		if (cs_fall) begin
			nxt_st.bitcnt = 6'h00;
			nxt_st.sh = 32'h0;
			nxt_st.idx = 3'h7;
		end else if (!cs_n_s && sck_rise && st_ff.bitcnt < 6'h30) begin
			if (st_ff.quad) begin
				nxt_st.sh = {st_ff.sh[27:0], st_ff.io_s2};
			end else begin
				nxt_st.sh = {st_ff.sh[30:0], st_ff.io_s2[0]};
			end
			nxt_st.bitcnt = st_ff.bitcnt + width;
			if (st_ff.bitcnt + width == 6'h08) begin
				nxt_st.cmd = st_ff.quad ? {st_ff.sh[3:0], st_ff.io_s2}
					: {st_ff.sh[6:0], st_ff.io_s2[0]};
			end
		end
		// Identification byte repeats MSB first on falling edges.
		if (!cs_n_s && sck_fall && st_ff.cmd == `FRPD_CMD_RELEASE
			&& st_ff.bitcnt >= 6'h20 && st_ff.wip_cnt == 16'h0000) begin
			nxt_st.so = ID_BYTE[st_ff.idx];
			nxt_st.idx = st_ff.idx - 3'h1;
		end
		// Commands act at the select rise; partial bytes do nothing.
		if (cs_rise && st_ff.pwr != FRPD_DEV_ENTERING
			&& st_ff.pwr != FRPD_DEV_WAKING && st_ff.bitcnt >= 6'h08) begin
			nxt_st.rst_en = 1'b0;
			if (st_ff.pwr == FRPD_DEV_PDOWN) begin
				// Everything else is ignored while powered down.
				if (st_ff.cmd == `FRPD_CMD_RELEASE) begin
					nxt_st.pwr = FRPD_DEV_WAKING;
					nxt_st.timer = (st_ff.bitcnt >= 6'h20) ? 16'(WAKE_WITH_ID_RECOVERY_TIME_CYC)
						: 16'(WAKE_RECOVERY_TIME_CYC);
				end else if (st_ff.cmd == `FRPD_CMD_RST_EN && cmd_ok) begin
					nxt_st.rst_en = 1'b1;
				end else if (st_ff.cmd == `FRPD_CMD_RST && cmd_ok
					&& st_ff.rst_en) begin
					nxt_st.pwr = FRPD_DEV_STANDBY;
					nxt_st.dummy_count_select = `FRPD_DUMMY_RST;
					nxt_st.wrap_disable_bit = `FRPD_WRAPDIS_RST;
					nxt_st.wrap_length_select = `FRPD_WRAPLEN_RST;
					nxt_st.quad = 1'b0;
					nxt_st.wel = 1'b0;
				end
			end else begin
				unique case (st_ff.cmd)
					`FRPD_CMD_SET_PARAM: if (st_ff.quad
						&& st_ff.bitcnt >= 6'h10) begin
						nxt_st.dummy_count_select =
							st_ff.sh[`FRPD_DUMMY_BIT +: 2];
						nxt_st.wrap_disable_bit =
							st_ff.sh[`FRPD_WRAPDIS_BIT];
						nxt_st.wrap_length_select =
							st_ff.sh[`FRPD_WRAPLEN_BIT +: 2];
					end
					`FRPD_CMD_WRAP: if (!st_ff.quad
						&& st_ff.bitcnt >= 6'h28) begin
						nxt_st.wrap_length_select =
							st_ff.sh[`FRPD_WRAP_WLEN_BIT +: 2];
						nxt_st.wrap_disable_bit =
							st_ff.sh[`FRPD_WRAP_WDIS_BIT];
					end
					`FRPD_CMD_PDOWN: if (cmd_ok
						&& st_ff.wip_cnt == 16'h0000) begin
						nxt_st.pwr = FRPD_DEV_ENTERING;
						nxt_st.timer = 16'(TDP_CYC);
					end
					`FRPD_CMD_QPI_ON: if (cmd_ok) begin
						nxt_st.quad = 1'b1;
					end
					`FRPD_CMD_QPI_OFF: if (cmd_ok && st_ff.quad) begin
						nxt_st.quad = 1'b0;
						nxt_st.dummy_count_select = `FRPD_DUMMY_RST;
					end
					`FRPD_CMD_WREN: if (cmd_ok) begin
						nxt_st.wel = 1'b1;
					end
					`FRPD_CMD_PP, `FRPD_CMD_SE: if (st_ff.wel
						&& st_ff.wip_cnt == 16'h0000) begin
						nxt_st.wel = 1'b0;
						nxt_st.wip_cnt = 16'(WIP_CYC);
					end
					`FRPD_CMD_RST_EN: if (cmd_ok) begin
						nxt_st.rst_en = 1'b1;
					end
					`FRPD_CMD_RST: if (cmd_ok && st_ff.rst_en) begin
						nxt_st.dummy_count_select = `FRPD_DUMMY_RST;
						nxt_st.wrap_disable_bit = `FRPD_WRAPDIS_RST;
						nxt_st.wrap_length_select = `FRPD_WRAPLEN_RST;
						nxt_st.quad = 1'b0;
						nxt_st.wel = 1'b0;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			st_ff <= '{cs_s: 3'h7, sck_s: 3'h0, io_s1: 4'h0, io_s2: 4'h0,
				bitcnt: 6'h00, cmd: 8'h00, sh: 32'h0, quad: 1'b0,
				rst_en: 1'b0, dummy_count_select: `FRPD_DUMMY_RST,
				wrap_disable_bit: `FRPD_WRAPDIS_RST,
				wrap_length_select: `FRPD_WRAPLEN_RST,
				pwr: FRPD_DEV_STANDBY, timer: 16'h0000,
				wip_cnt: 16'h0000, wel: 1'b0, idx: 3'h7,
				so: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Address walk: wrap keeps the upper bits and rolls the low ones.
	always_comb begin
		NEXT_ADDR = READ_ADDR + 24'h000001;
		if (st_ff.quad && (DEDICATED_WRAP_READ
			|| !st_ff.wrap_disable_bit)) begin
			NEXT_ADDR = {READ_ADDR[23:6], (READ_ADDR[5:0] & ~mask)
				| ((READ_ADDR[5:0] + 6'h01) & mask)};
		end
	end

	assign LINK.io_dev = {3'h0, st_ff.so};
	assign LINK.io_dev_oe = {3'h0, !cs_n_s && st_ff.cmd == `FRPD_CMD_RELEASE
		&& st_ff.bitcnt >= 6'h20};
	assign QUAD_MODE = st_ff.quad;
	assign DEEP_POWER_DOWN = (st_ff.pwr == FRPD_DEV_PDOWN);
	assign STANDBY = cs_n_s && st_ff.pwr == FRPD_DEV_STANDBY
		&& st_ff.wip_cnt == 16'h0000;
	assign BUSY_RECOVERING = (st_ff.pwr == FRPD_DEV_WAKING);
	assign WRITE_IN_PROGRESS_FLAG = (st_ff.wip_cnt != 16'h0000);
	assign DUMMY_CLOCKS = dummy_of(st_ff.dummy_count_select);
	assign WRAP_DISABLE_BIT = st_ff.wrap_disable_bit;
	assign WRAP_BYTES = wrap_of(st_ff.wrap_length_select);
endmodule // frpd_device

//--- frpd_host.sv
// Host controller end: frames commands on the flash link.
`timescale 1ns/1ps
`include "frpd_defs.svh"
module frpd_host #(
	parameter int WAKE_WITH_ID_RECOVERY_TIME_CYC = `FRPD_WAKE_WITH_ID_RECOVERY_TIME_CYC
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Link
	frpd_link_if.host LINK,
	// Request
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic QUAD,
	input wire logic [31:0] REQ_DATA,
	input wire logic [5:0] REQ_BITS,
	// Answer
	output logic [7:0] RX_BYTE,
	output logic DONE
);
	import frpd_pkg::*;

	typedef struct packed {
		frpd_hstate_t st;
		logic [31:0] sh;
		logic [5:0] left;
		logic quad;
		logic [$clog2(`FRPD_HOST_DIV)-1:0] div;
		logic sck;
		logic cs_n;
		logic [15:0] gap;
		logic [1:0] rx_s;
		logic [7:0] rx;
		logic done;
	} frpd_host_state_t;

	frpd_host_state_t st_ff;
	frpd_host_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.rx_s = {st_ff.rx_s[0], LINK.io_dev[0]};
		unique case (st_ff.st)
			FRPD_H_IDLE: if (REQ_VALID) begin
				nxt_st.st = FRPD_H_SHIFT;
				nxt_st.sh = REQ_DATA;
				nxt_st.left = REQ_BITS;
				nxt_st.quad = QUAD;
				nxt_st.cs_n = 1'b0;
				nxt_st.div = '0;
			end
			FRPD_H_SHIFT: begin
				nxt_st.div = st_ff.div + 1'b1;
				if (&st_ff.div) begin
					nxt_st.sck = ~st_ff.sck;
					if (st_ff.sck) begin
						// Falling edge: move to the next bit or nibble.
						if (st_ff.quad) begin
							nxt_st.sh = {st_ff.sh[27:0], 4'h0};
							nxt_st.left = st_ff.left - 6'h04;
						end else begin
							nxt_st.sh = {st_ff.sh[30:0], 1'b0};
							nxt_st.left = st_ff.left - 6'h01;
						end
						nxt_st.rx = {st_ff.rx[6:0], st_ff.rx_s[1]};
						if (st_ff.left <= (st_ff.quad ? 6'h04 : 6'h01)) begin
							nxt_st.cs_n = 1'b1;
							nxt_st.st = FRPD_H_GAP;
							nxt_st.gap = 16'(WAKE_WITH_ID_RECOVERY_TIME_CYC);
						end
					end
				end
			end
			FRPD_H_GAP: begin
				nxt_st.gap = st_ff.gap - 16'h0001;
				if (st_ff.gap == 16'h0000) begin
					nxt_st.st = FRPD_H_IDLE;
					nxt_st.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			st_ff <= '{st: FRPD_H_IDLE, sh: 32'h0, left: 6'h00, quad: 1'b0,
				div: '0, sck: 1'b0, cs_n: 1'b1, gap: 16'h0000,
				rx_s: 2'h0, rx: 8'h00, done: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign REQ_READY = (st_ff.st == FRPD_H_IDLE);
	assign LINK.cs_n = st_ff.cs_n;
	assign LINK.sck = st_ff.sck;
	assign LINK.io_host = st_ff.quad ? st_ff.sh[31:28] : {3'h0, st_ff.sh[31]};
	assign LINK.io_host_oe = (st_ff.st == FRPD_H_SHIFT)
		? (st_ff.quad ? 4'hF : 4'h1) : 4'h0;
	assign RX_BYTE = st_ff.rx;
	assign DONE = st_ff.done;
endmodule // frpd_host

//--- frpd_link_sva.sv
// Checker for the flash link: relations among device state and select.
`timescale 1ns/1ps
module frpd_link_sva (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Link and device state
	input wire logic cs_n,
	input wire logic QUAD_MODE,
	input wire logic DEEP_POWER_DOWN,
	input wire logic STANDBY,
	input wire logic BUSY_RECOVERING,
	input wire logic WRITE_IN_PROGRESS_FLAG,
	input wire logic [3:0] DUMMY_CLOCKS,
	input wire logic [6:0] WRAP_BYTES
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	a_dummy_count_legal: assert property (
		DUMMY_CLOCKS inside {4'h4, 4'h6, 4'h8})
		else $error("dummy count outside the legal set");
	a_wrap_len_legal: assert property (
		WRAP_BYTES inside {7'h08, 7'h10, 7'h20, 7'h40})
		else $error("wrap length outside the legal set");
	a_serial_dummy_default: assert property (
		!QUAD_MODE && $past(!QUAD_MODE) |-> DUMMY_CLOCKS == 4'h8)
		else $error("serial mode dummy count is not the default");
	a_standby_not_pdown: assert property (
		STANDBY |-> !DEEP_POWER_DOWN && !BUSY_RECOVERING)
		else $error("standby overlaps power-down or wake");
	a_pdown_no_write: assert property (
		$rose(DEEP_POWER_DOWN) |-> !WRITE_IN_PROGRESS_FLAG)
		else $error("power-down entered during a write cycle");
	a_pdown_after_select: assert property (
		$rose(DEEP_POWER_DOWN) |-> cs_n && $past(cs_n, 4))
		else $error("power-down entered too soon after select rise");
	a_wake_select_high: assert property (
		BUSY_RECOVERING |-> cs_n)
		else $error("select driven low during wake recovery");
	a_pdown_no_program: assert property (
		DEEP_POWER_DOWN |-> !$rose(WRITE_IN_PROGRESS_FLAG))
		else $error("write cycle started in power-down");
endmodule // frpd_link_sva

//--- tb_flash_read_param_power_down.sv
// Testbench joining host and device ends over the flash link.
`timescale 1ns/1ps
module tb_flash_read_param_power_down;
	logic mclk = 0;
	logic resetn = 0;
	logic req_valid = 0;
	logic quad = 0;
	logic ded_wrap = 0;
	logic [31:0] req_data = 0;
	logic [5:0] req_bits = 0;
	logic [23:0] read_addr = 0;
	logic [23:0] next_addr;
	logic [7:0] rx_byte;
	logic req_ready, done, quad_mode, pdown, standby, waking, write_in_progress_flag, wrap_dis;
	logic [3:0] dummy;
	logic [6:0] wrap_bytes;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	localparam logic [7:0] ID = 8'h5A; // Arbitrary value.
	always #2 mclk = ~mclk;
	frpd_link_if frpd_link_if_inst ();
	frpd_host #(.WAKE_WITH_ID_RECOVERY_TIME_CYC(16)) frpd_host_inst (.MCLK(mclk),
		.RESETN(resetn), .LINK(frpd_link_if_inst.host),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .QUAD(quad),
		.REQ_DATA(req_data), .REQ_BITS(req_bits), .RX_BYTE(rx_byte),
		.DONE(done));
	frpd_device #(.ID_BYTE(ID), .TDP_CYC(8), .WAKE_RECOVERY_TIME_CYC(8), .WAKE_WITH_ID_RECOVERY_TIME_CYC(8),
		.WIP_CYC(600)) frpd_device_inst (.MCLK(mclk), .RESETN(resetn),
		.LINK(frpd_link_if_inst.dev), .QUAD_MODE(quad_mode),
		.DEEP_POWER_DOWN(pdown), .STANDBY(standby),
		.BUSY_RECOVERING(waking), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag),
		.DUMMY_CLOCKS(dummy), .WRAP_DISABLE_BIT(wrap_dis),
		.WRAP_BYTES(wrap_bytes), .READ_ADDR(read_addr),
		.DEDICATED_WRAP_READ(ded_wrap), .NEXT_ADDR(next_addr));
	frpd_link_sva frpd_link_sva_inst (.MCLK(mclk), .RESETN(resetn),
		.cs_n(frpd_link_if_inst.cs_n), .QUAD_MODE(quad_mode),
		.DEEP_POWER_DOWN(pdown), .STANDBY(standby),
		.BUSY_RECOVERING(waking), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag),
		.DUMMY_CLOCKS(dummy), .WRAP_BYTES(wrap_bytes));
	task chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Data is left-aligned; the host shifts from bit 31 downward.
	task xfer(input logic q, input logic [31:0] d, input int n);
		int k;
		@(negedge mclk);
		quad = q;
		req_data = d;
		req_bits = 6'(n);
		req_valid = 1;
		@(negedge mclk);
		req_valid = 0;
		for (k = 0; k < 800 && done !== 1'b1; k++)
			@(negedge mclk);
		chk(done, 24'h1);
		repeat (4) @(negedge mclk);
	endtask
	task t_defaults;
		chk(dummy, 24'h8);
		chk(wrap_bytes, 24'h8);
		chk(wrap_dis, 24'h1);
		chk({pdown, standby}, 24'h1);
	endtask
	task t_quad_params;
		xfer(1'b0, 32'h38000000, 8);
		chk(quad_mode, 24'h1);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, {8'hC0, 2'h0, 2'(i), 2'h0, 2'(i), 16'h0}, 16);
			chk(dummy, i < 2 ? 24'h4 : (i == 2 ? 24'h6 : 24'h8));
			chk(wrap_bytes, 24'h8 << i);
			chk(wrap_dis, 24'h0);
		end
	endtask
	task t_wrap;
		read_addr = 24'h00017F;
		@(negedge mclk);
		chk(next_addr, 24'h000140);
		xfer(1'b1, 32'hC0250000, 16);
		read_addr = 24'h00012F;
		@(negedge mclk);
		chk(next_addr, 24'h000130);
		ded_wrap = 1;
		@(negedge mclk);
		chk(next_addr, 24'h000120);
		ded_wrap = 0;
	endtask
	task t_quad_exit;
		xfer(1'b1, 32'hFF000000, 8);
		chk({quad_mode, dummy}, 24'h08);
		chk(wrap_bytes, 24'h10);
		xfer(1'b0, 32'hC0000000, 16);
		chk({dummy, wrap_bytes}, {13'h0, 4'h8, 7'h10});
	endtask
	// The wrap byte trails the 32 data bits, so it arrives as zeros.
	task t_wrap_reset;
		xfer(1'b0, 32'h77000000, 40);
		chk({wrap_dis, wrap_bytes}, 24'h08);
		xfer(1'b0, 32'h38000000, 8);
		xfer(1'b1, 32'hC0210000, 16);
		xfer(1'b1, 32'h66000000, 8);
		xfer(1'b1, 32'h99000000, 8);
		chk({quad_mode, dummy, wrap_dis, wrap_bytes}, 24'h888);
	endtask
	task t_pdown;
		xfer(1'b0, 32'hB9000000, 16);
		chk(pdown, 24'h0);
		xfer(1'b0, 32'hB9000000, 8);
		chk({pdown, standby}, 24'h2);
		xfer(1'b0, 32'h06000000, 8);
		xfer(1'b0, 32'h02000000, 8);
		xfer(1'b0, 32'h38000000, 8);
		chk({write_in_progress_flag, quad_mode, pdown}, 24'h1);
		xfer(1'b0, 32'hAB000000, 8);
		chk({req_ready, waking, pdown, standby}, 24'h9);
		xfer(1'b0, 32'hB9000000, 8);
		xfer(1'b0, 32'hABFFFFFF, 40);
		chk({rx_byte, pdown}, {15'h0, ID, 1'b0});
	endtask
	task t_wip;
		int k;
		xfer(1'b0, 32'h06000000, 8);
		xfer(1'b0, 32'h02000000, 8);
		xfer(1'b0, 32'hB9000000, 8);
		xfer(1'b0, 32'hABFFFFFF, 40);
		chk({write_in_progress_flag, pdown, rx_byte === ID}, 24'h4);
		for (k = 0; k < 700 && write_in_progress_flag !== 1'b0; k++)
			@(negedge mclk);
		chk({write_in_progress_flag, standby}, 24'h1);
		xfer(1'b0, 32'hB9000000, 8);
		xfer(1'b0, 32'h66000000, 8);
		xfer(1'b0, 32'h99000000, 8);
		chk({pdown, standby}, 24'h1);
	endtask
	task final_report;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge mclk);
		resetn = 1;
		@(negedge mclk);
		t_defaults();
		t_quad_params();
		t_wrap();
		t_quad_exit();
		t_wrap_reset();
		t_pdown();
		t_wip();
		final_report();
	end
	// The run needs well under half of this ceiling.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end
endmodule // tb_flash_read_param_power_down
